// >>> src/mre_pkg.sv
// constants shared by the mouse report endpoint and its button debouncer
// assumes a single 50 MHz clock and synchronous inputs
`default_nettype none
package mre_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   // device states as signalled by the enumeration logic
   localparam logic [1:0]  DEV_DEFAULT     = 2'h0;
   localparam logic [1:0]  DEV_ADDRESSED   = 2'h1;
   localparam logic [1:0]  DEV_CONFIGURED  = 2'h2;
   // answer given to a poll of the report endpoint
   localparam logic [1:0]  RESP_NAK        = 2'h1;
   localparam logic [1:0]  RESP_DATA       = 2'h2;
   localparam logic [1:0]  RESP_STALL      = 2'h3;
   // field widths
   localparam int unsigned XY_W            = 12;
   localparam int unsigned Z_W             = 8;
   localparam int unsigned BTN_W           = 3;
   localparam logic [2:0]  LEN_NO_WHEEL    = 3'h4;
   localparam logic [2:0]  LEN_WHEEL       = 3'h5;
   // saturation limits on a 13-bit signed sum
   localparam logic signed [12:0] XY_MAX   = 13'sh07FF;
   localparam logic signed [12:0] XY_MIN   = 13'sh1800;
   localparam logic signed [12:0] Z_MAX    = 13'sh007F;
   localparam logic signed [12:0] Z_MIN    = 13'sh1F80;
   // idle repeat rate unit
   localparam int unsigned IDLE_UNIT_MS    = 4;
   localparam int unsigned IDLE_UNIT_CYCLES = (CLK_HZ / 1000) * IDLE_UNIT_MS;
   // button debounce settle time
   localparam int unsigned DEBOUNCE_US     = 50;
   localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
   localparam logic [11:0] DEBOUNCE_LAST   = 12'(DEBOUNCE_CYCLES - 1);
endpackage
`default_nettype wire

// >>> src/mre_debounce.sv
// button debouncer: a raw level is taken once stable for the settle time
// assumes button inputs already synchronous to i_clk
`default_nettype none
module mre_debounce (
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   input  wire logic [2:0] i_raw,
   output logic      [2:0] o_stable
);
   logic [2:0]  cand_r;
   logic [2:0]  cand_nxt;
   logic [2:0]  stable_r;
   logic [2:0]  stable_nxt;
   logic [11:0] cnt_r;
   logic [11:0] cnt_nxt;

   always_comb begin
      cand_nxt   = cand_r;
      stable_nxt = stable_r;
      cnt_nxt    = cnt_r;
      if (i_raw != cand_r) begin
         cand_nxt = i_raw;
         cnt_nxt  = 12'h000;
      end else if (cnt_r == mre_pkg::DEBOUNCE_LAST) begin
         stable_nxt = cand_r;
      end else begin
         cnt_nxt = cnt_r + 12'h001;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cand_r   <= 3'h0;
         stable_r <= 3'h0;
         cnt_r    <= 12'h000;
      end else begin
         cand_r   <= cand_nxt;
         stable_r <= stable_nxt;
         cnt_r    <= cnt_nxt;
      end
   end

   assign o_stable = stable_r;
endmodule
`default_nettype wire

// >>> src/mre_endpoint.sv
// report endpoint of a low-speed mouse: poll answers, motion accumulation
// assumes the protocol engine decodes tokens, handshakes and requests
// How it works
// R1 - packet: buttons, X low, XY high, Y low, wheel
// R2 - configured and not halted: NAK when empty, else data
// R3 - STALL only while halt bit is set
// R4 - host polls at least every 10 frames
// R5 - back-to-back polls never lose or duplicate
// R6 - no reports unless configured; polls ignored
// R7 - empty buffer loads any change at once
// R8 - full buffer: motion summed into accumulators
// R9 - on emptying, accumulated totals become next report
// R10 - accumulators cleared right after that transfer
// R11 - reported button state saved as copy
// R12 - full buffer ignores button changes
// R13 - on emptying, changed buttons load and update copy
// R14 - buttons debounced before use
// R15 - zero wLength queries still return one byte
// R16 - halt set/clear only accepted when configured
// R17 - idle rate in 4 ms units, zero means on-change
// R18 - buffer empties only on host acknowledge or when not configured
// R19 - accumulators saturate at field limits
`default_nettype none
module mre_endpoint #(
   parameter int unsigned IDLE_UNIT = mre_pkg::IDLE_UNIT_CYCLES
) (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic [1:0]  i_dev_state,
   input  wire logic        i_report_endpoint_poll,
   input  wire logic        i_host_ack,
   input  wire logic        i_halt_report_endpoint_request,
   input  wire logic        i_unhalt_report_endpoint_request,
   input  wire logic        i_set_idle,
   input  wire logic [7:0]  i_idle_rate,
   input  wire logic        i_query_valid,
   input  wire logic [15:0] i_query_wlength,
   input  wire logic [7:0]  i_query_natural_len,
   input  wire logic        i_motion_valid,
   input  wire logic [11:0] i_dx,
   input  wire logic [11:0] i_dy,
   input  wire logic [7:0]  i_dz,
   input  wire logic        i_wheel_present,
   input  wire logic [2:0]  i_buttons_raw,
   output logic             o_resp_valid,
   output logic [1:0]       o_resp_kind,
   output logic [2:0]       o_resp_len,
   output logic [7:0]       o_resp_byte0,
   output logic [7:0]       o_resp_byte1,
   output logic [7:0]       o_resp_byte2,
   output logic [7:0]       o_resp_byte3,
   output logic [7:0]       o_resp_byte4,
   output logic             o_ctrl_valid,
   output logic             o_ctrl_stall,
   output logic             o_halted,
   output logic             o_query_valid,
   output logic [7:0]       o_query_len
);
   function automatic logic [11:0] sat_add(input logic [11:0] a,
                                           input logic [11:0] b,
                                           input logic signed [12:0] lo,
                                           input logic signed [12:0] hi);
      logic signed [12:0] s;
      s = $signed({a[11], a}) + $signed({b[11], b});
      if (s > hi) begin
         return hi[11:0];
      end else if (s < lo) begin
         return lo[11:0];
      end
      return s[11:0];
   endfunction

   logic [2:0]  btn;
   logic        cfg;
   logic        emptying;
   logic        free;
   logic        load;
   logic        idle_fire;
   logic [11:0] sum_x;
   logic [11:0] sum_y;
   logic [11:0] sum_z;

   logic        full_r,  full_nxt;
   logic        sent_r,  sent_nxt;
   logic [2:0]  rep_b_r, rep_b_nxt;
   logic [11:0] rep_x_r, rep_x_nxt;
   logic [11:0] rep_y_r, rep_y_nxt;
   logic [7:0]  rep_z_r, rep_z_nxt;
   logic [11:0] acc_x_r, acc_x_nxt;
   logic [11:0] acc_y_r, acc_y_nxt;
   logic [7:0]  acc_z_r, acc_z_nxt;
   logic [2:0]  saved_r, saved_nxt;

   mre_debounce u_debounce (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_raw    (i_buttons_raw),
      .o_stable (btn)
   ); // see R14

   assign cfg      = (i_dev_state == mre_pkg::DEV_CONFIGURED);
   assign emptying = cfg & full_r & sent_r & i_host_ack; // see R18
   assign free     = ~full_r | emptying;

   // motion of this cycle folded into the running totals
   always_comb begin
      sum_x = acc_x_r;
      sum_y = acc_y_r;
      sum_z = {{4{acc_z_r[7]}}, acc_z_r};
      if (i_motion_valid) begin
         sum_x = sat_add(acc_x_r, i_dx, mre_pkg::XY_MIN,
                         mre_pkg::XY_MAX); // see R19
         sum_y = sat_add(acc_y_r, i_dy, mre_pkg::XY_MIN, mre_pkg::XY_MAX);
         if (i_wheel_present) begin
            sum_z = sat_add({{4{acc_z_r[7]}}, acc_z_r},
                            {{4{i_dz[7]}}, i_dz},
                            mre_pkg::Z_MIN, mre_pkg::Z_MAX);
         end
      end
   end

   // see R7, R9, R13
   assign load = cfg & free & ((sum_x != 12'h000) | (sum_y != 12'h000) |
                 (sum_z != 12'h000) | (btn != saved_r) | idle_fire);

   always_comb begin
      full_nxt  = full_r;
      sent_nxt  = sent_r;
      rep_b_nxt = rep_b_r;
      rep_x_nxt = rep_x_r;
      rep_y_nxt = rep_y_r;
      rep_z_nxt = rep_z_r;
      acc_x_nxt = sum_x; // see R8
      acc_y_nxt = sum_y;
      acc_z_nxt = sum_z[7:0];
      saved_nxt = saved_r; // see R12
      if (!cfg) begin
         full_nxt  = 1'b0; // see R6
         sent_nxt  = 1'b0;
         acc_x_nxt = 12'h000;
         acc_y_nxt = 12'h000;
         acc_z_nxt = 8'h00;
      end else begin
         if (emptying) begin
            full_nxt = 1'b0;
            sent_nxt = 1'b0;
         end else if (i_report_endpoint_poll && full_r && !o_halted) begin
            sent_nxt = 1'b1; // see R5
         end
         if (load) begin
            full_nxt  = 1'b1;
            sent_nxt  = 1'b0;
            rep_b_nxt = btn;
            rep_x_nxt = sum_x;
            rep_y_nxt = sum_y;
            rep_z_nxt = sum_z[7:0];
            saved_nxt = btn; // see R11
            acc_x_nxt = 12'h000; // see R10
            acc_y_nxt = 12'h000;
            acc_z_nxt = 8'h00;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         full_r  <= 1'b0;
         sent_r  <= 1'b0;
         rep_b_r <= 3'h0;
         rep_x_r <= 12'h000;
         rep_y_r <= 12'h000;
         rep_z_r <= 8'h00;
         acc_x_r <= 12'h000;
         acc_y_r <= 12'h000;
         acc_z_r <= 8'h00;
         saved_r <= 3'h0;
      end else begin
         full_r  <= full_nxt;
         sent_r  <= sent_nxt;
         rep_b_r <= rep_b_nxt;
         rep_x_r <= rep_x_nxt;
         rep_y_r <= rep_y_nxt;
         rep_z_r <= rep_z_nxt;
         acc_x_r <= acc_x_nxt;
         acc_y_r <= acc_y_nxt;
         acc_z_r <= acc_z_nxt;
         saved_r <= saved_nxt;
      end
   end

   // idle repeat timer
   logic [7:0]  rate_r,  rate_nxt;
   logic [17:0] tick_r,  tick_nxt;
   logic [7:0]  units_r, units_nxt;

   assign idle_fire = (rate_r != 8'h00) && !full_r &&
                      (units_r == rate_r); // see R17

   always_comb begin
      rate_nxt  = rate_r;
      tick_nxt  = tick_r;
      units_nxt = units_r;
      if (i_set_idle) begin
         rate_nxt = i_idle_rate;
      end
      if (!cfg || full_r || load || rate_r == 8'h00) begin
         tick_nxt  = 18'h00000;
         units_nxt = 8'h00;
      end else if (tick_r == 18'(IDLE_UNIT - 1)) begin
         tick_nxt  = 18'h00000;
         units_nxt = units_r + 8'h01;
      end else begin
         tick_nxt = tick_r + 18'h00001;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rate_r  <= 8'h00;
         tick_r  <= 18'h00000;
         units_r <= 8'h00;
      end else begin
         rate_r  <= rate_nxt;
         tick_r  <= tick_nxt;
         units_r <= units_nxt;
      end
   end

   // answers to polls, halt requests and short queries
   logic        rv_nxt, cv_nxt, cs_nxt, halt_nxt, qv_nxt;
   logic [1:0]  rk_nxt;
   logic [2:0]  rl_nxt;
   logic [7:0]  b0_nxt, b1_nxt, b2_nxt, b3_nxt, b4_nxt, ql_nxt;

   always_comb begin
      rv_nxt   = 1'b0;
      rk_nxt   = o_resp_kind;
      rl_nxt   = o_resp_len;
      b0_nxt   = o_resp_byte0;
      b1_nxt   = o_resp_byte1;
      b2_nxt   = o_resp_byte2;
      b3_nxt   = o_resp_byte3;
      b4_nxt   = o_resp_byte4;
      cv_nxt   = 1'b0;
      cs_nxt   = o_ctrl_stall;
      halt_nxt = o_halted;
      qv_nxt   = 1'b0;
      ql_nxt   = o_query_len;
      if (cfg && i_report_endpoint_poll) begin // see R6
         rv_nxt = 1'b1;
         if (o_halted) begin
            rk_nxt = mre_pkg::RESP_STALL; // see R3
         end else if (full_r && !emptying) begin // see R5
            rk_nxt = mre_pkg::RESP_DATA; // see R2
            rl_nxt = i_wheel_present ? mre_pkg::LEN_WHEEL
                                     : mre_pkg::LEN_NO_WHEEL;
            b0_nxt = {5'h00, rep_b_r}; // see R1
            b1_nxt = rep_x_r[7:0];
            b2_nxt = {rep_y_r[11:8], rep_x_r[11:8]};
            b3_nxt = rep_y_r[7:0];
            b4_nxt = i_wheel_present ? rep_z_r : 8'h00;
         end else begin
            rk_nxt = mre_pkg::RESP_NAK; // see R2
         end
      end
      if (i_halt_report_endpoint_request ||
          i_unhalt_report_endpoint_request) begin
         cv_nxt = 1'b1;
         cs_nxt = !cfg; // see R16
         if (cfg) begin
            halt_nxt = i_halt_report_endpoint_request;
         end
      end
      if (i_query_valid) begin
         qv_nxt = 1'b1;
         if (i_query_wlength == 16'h0000) begin
            ql_nxt = 8'h01; // see R15
         end else if (i_query_wlength < {8'h00, i_query_natural_len}) begin
            ql_nxt = i_query_wlength[7:0];
         end else begin
            ql_nxt = i_query_natural_len;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_resp_valid  <= 1'b0;
         o_resp_kind   <= 2'h0;
         o_resp_len    <= 3'h0;
         o_resp_byte0  <= 8'h00;
         o_resp_byte1  <= 8'h00;
         o_resp_byte2  <= 8'h00;
         o_resp_byte3  <= 8'h00;
         o_resp_byte4  <= 8'h00;
         o_ctrl_valid  <= 1'b0;
         o_ctrl_stall  <= 1'b0;
         o_halted      <= 1'b0;
         o_query_valid <= 1'b0;
         o_query_len   <= 8'h00;
      end else begin
         o_resp_valid  <= rv_nxt;
         o_resp_kind   <= rk_nxt;
         o_resp_len    <= rl_nxt;
         o_resp_byte0  <= b0_nxt;
         o_resp_byte1  <= b1_nxt;
         o_resp_byte2  <= b2_nxt;
         o_resp_byte3  <= b3_nxt;
         o_resp_byte4  <= b4_nxt;
         o_ctrl_valid  <= cv_nxt;
         o_ctrl_stall  <= cs_nxt;
         o_halted      <= halt_nxt;
         o_query_valid <= qv_nxt;
         o_query_len   <= ql_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> src/dummy_end.sv
`default_nettype none
`default_nettype wire

// >>> test/mre_endpoint_sva.sv
// checker: poll, halt and query answers of the report endpoint
// assumes a bind onto mre_endpoint in one clock domain
`default_nettype none
module mre_endpoint_sva (
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic [1:0]  i_dev_state,
   input wire logic        i_report_endpoint_poll,
   input wire logic        i_halt_report_endpoint_request,
   input wire logic        i_unhalt_report_endpoint_request,
   input wire logic        i_query_valid,
   input wire logic [15:0] i_query_wlength,
   input wire logic        i_wheel_present,
   input wire logic        o_resp_valid,
   input wire logic [1:0]  o_resp_kind,
   input wire logic [2:0]  o_resp_len,
   input wire logic        o_ctrl_valid,
   input wire logic        o_ctrl_stall,
   input wire logic        o_halted,
   input wire logic        o_query_valid,
   input wire logic [7:0]  o_query_len
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   wire logic cfg = i_dev_state == mre_pkg::DEV_CONFIGURED;
   wire logic poll = i_report_endpoint_poll;
   wire logic hreq = i_halt_report_endpoint_request
                     || i_unhalt_report_endpoint_request;
   a_poll_answer: assert property (poll && cfg |=> o_resp_valid)
      else $error("poll not answered");
   a_poll_ignore: assert property (poll && !cfg |=> !o_resp_valid)
      else $error("poll answered while not configured");
   a_halt_stall: assert property (
      poll && cfg && o_halted |=> o_resp_kind == mre_pkg::RESP_STALL)
      else $error("halted poll not stalled");
   a_stall_cause: assert property (
      o_resp_valid && o_resp_kind == mre_pkg::RESP_STALL |-> $past(o_halted))
      else $error("stall without halt bit");
   a_data_len: assert property (
      o_resp_valid && o_resp_kind == mre_pkg::RESP_DATA |-> o_resp_len ==
      ($past(i_wheel_present) ? mre_pkg::LEN_WHEEL
                              : mre_pkg::LEN_NO_WHEEL))
      else $error("wrong report length");
   a_ctrl_answer: assert property (
      hreq |=> o_ctrl_valid && o_ctrl_stall == !$past(cfg) ##1 !o_ctrl_valid)
      else $error("halt request answer wrong");
   a_halt_set: assert property (
      i_halt_report_endpoint_request && cfg |=> o_halted)
      else $error("halt bit not set");
   a_halt_clear: assert property (
      i_unhalt_report_endpoint_request && !i_halt_report_endpoint_request
      && cfg |=> !o_halted)
      else $error("halt bit not cleared");
   a_query_one: assert property (
      i_query_valid && i_query_wlength == 16'h0000
      |=> o_query_valid && o_query_len == 8'h01)
      else $error("zero length query not one byte");
endmodule
`default_nettype wire

// >>> test/mre_host.sv
// host model: polls the report endpoint, acknowledges data answers
// assumes the bench calls poll() and then reads got, kind and pkt
`default_nettype none
module mre_host (
   input  wire logic        i_clk,
   input  wire logic        i_valid,
   input  wire logic [1:0]  i_kind,
   input  wire logic [39:0] i_pkt,
   output logic             o_poll,
   output logic             o_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        got;
   logic [1:0]  kind;
   logic [39:0] pkt;
   initial begin
      o_poll = 1'b0;
      o_ack = 1'b0;
   end
   // polls come a few cycles apart, far inside the frame limit
   task automatic poll(input bit ack);
      got = 1'b0;
      @(posedge i_clk) #2 o_poll = 1'b1;
      @(posedge i_clk) #2 o_poll = 1'b0;
      repeat (3) begin
         if (!got && i_valid === 1'b1) begin
            got = 1'b1;
            kind = i_kind;
            pkt = i_pkt;
         end
         @(posedge i_clk) #2;
      end
      if (ack && got && kind === mre_pkg::RESP_DATA) begin
         o_ack = 1'b1;
         @(posedge i_clk) #2 o_ack = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> test/tb_mre_endpoint.sv
// bench for the report endpoint: host model polls, bench drives the rest
// assumes a 20-cycle idle unit so the repeat timer fires quickly
`default_nettype none
module tb_mre_endpoint;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk, i_reset, motion, halt, unhalt, query, poll, ack;
   logic        rv, cv, cs, hd, qv;
   logic        wheel, sidle;
   logic [7:0]  rate;
   logic [1:0]  state, kind;
   logic [2:0]  btn, len;
   logic [7:0]  dz, nat, qlen, b0, b1, b2, b3, b4;
   logic [11:0] dx, dy;
   logic [15:0] wlen;
   int          n_fail, comparisons, cycles;
   wire logic [39:0] pkt = {b0, b1, b2, b3, b4};
   mre_endpoint #(.IDLE_UNIT(20)) dut_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_dev_state(state),
      .i_report_endpoint_poll(poll), .i_host_ack(ack),
      .i_halt_report_endpoint_request(halt),
      .i_unhalt_report_endpoint_request(unhalt),
      .i_set_idle(sidle), .i_idle_rate(rate), .i_query_valid(query),
      .i_query_wlength(wlen), .i_query_natural_len(nat),
      .i_motion_valid(motion), .i_dx(dx), .i_dy(dy), .i_dz(dz),
      .i_wheel_present(wheel), .i_buttons_raw(btn),
      .o_resp_valid(rv), .o_resp_kind(kind), .o_resp_len(len),
      .o_resp_byte0(b0), .o_resp_byte1(b1), .o_resp_byte2(b2),
      .o_resp_byte3(b3), .o_resp_byte4(b4), .o_ctrl_valid(cv),
      .o_ctrl_stall(cs), .o_halted(hd), .o_query_valid(qv),
      .o_query_len(qlen)
   );
   mre_host host_u (
      .i_clk(i_clk), .i_valid(rv), .i_kind(kind), .i_pkt(pkt),
      .o_poll(poll), .o_ack(ack)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk) #2;
   endtask
   task automatic chk(input string what, input logic [39:0] seen,
                      input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   task automatic mv(input logic [11:0] x, y, input logic [7:0] z);
      dx = x;
      dy = y;
      dz = z;
      pulse(motion);
   endtask
   task automatic pchk(input string what, input bit a,
                       input logic [1:0] k, input logic [39:0] p);
      logic [2:0] exp_len;
      exp_len = wheel ? mre_pkg::LEN_WHEEL : mre_pkg::LEN_NO_WHEEL;
      host_u.poll(a);
      chk(what, {38'h0, host_u.kind}, {38'h0, k});
      if (k == mre_pkg::RESP_DATA) begin
         chk(what, host_u.pkt, p);
         chk("length", {37'h0, len}, {37'h0, exp_len});
      end
   endtask
   task automatic t_unconf;
      state = mre_pkg::DEV_ADDRESSED;
      host_u.poll(1'b1);
      chk("ignored", {39'h0, host_u.got}, 40'h0);
      pulse(halt);
      chk("refused", {38'h0, cs, hd}, 40'h2);
      $display("test unconfigured done");
   endtask
   task automatic t_report;
      state = mre_pkg::DEV_CONFIGURED;
      pchk("empty", 0, mre_pkg::RESP_NAK, 0);
      mv(12'h003, 12'hFFE, 8'h01);
      pchk("first", 0, mre_pkg::RESP_DATA, 40'h0003F0FE01);
      mv(12'h7FF, 12'h001, 8'h00);
      mv(12'h7FF, 12'h001, 8'h00);
      pchk("resend", 0, mre_pkg::RESP_DATA, 40'h0003F0FE01);
      pchk("acked", 1, mre_pkg::RESP_DATA, 40'h0003F0FE01);
      pchk("summed", 1, mre_pkg::RESP_DATA, 40'h00FF070200);
      pchk("cleared", 0, mre_pkg::RESP_NAK, 0);
      $display("test report done");
   endtask
   task automatic t_button;
      btn = 3'h5;
      tick(2600);
      pchk("press", 1, mre_pkg::RESP_DATA, 40'h0500000000);
      mv(12'h001, 12'h000, 8'h00);
      btn = 3'h1;
      tick(2600);
      pchk("held", 1, mre_pkg::RESP_DATA, 40'h0501000000);
      pchk("newbtn", 1, mre_pkg::RESP_DATA, 40'h0100000000);
      $display("test button done");
   endtask
   task automatic t_nowheel;
      wheel = 1'b0;
      mv(12'h002, 12'h000, 8'h7F);
      pchk("nowheel", 1, mre_pkg::RESP_DATA, 40'h0102000000);
      wheel = 1'b1;
      $display("test no wheel done");
   endtask
   task automatic t_idle;
      rate = 8'h01;
      pulse(sidle);
      tick(30);
      pchk("repeat", 1, mre_pkg::RESP_DATA, 40'h0100000000);
      rate = 8'h00;
      pulse(sidle);
      tick(30);
      pchk("on change", 0, mre_pkg::RESP_NAK, 0);
      $display("test idle done");
   endtask
   task automatic t_halt;
      pulse(halt);
      chk("halted", {38'h0, cs, hd}, 40'h1);
      pchk("stall", 0, mre_pkg::RESP_STALL, 0);
      pulse(unhalt);
      pchk("unstall", 0, mre_pkg::RESP_NAK, 0);
      $display("test halt done");
   endtask
   task automatic t_query;
      nat = 8'h02;
      pulse(query);
      chk("zero len", {32'h0, qlen}, 40'h01);
      wlen = 16'h0005;
      pulse(query);
      chk("capped", {32'h0, qlen}, 40'h02);
      $display("test query done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   initial begin
      {motion, halt, unhalt, query, sidle, rate, dx, dy, dz, nat, wlen,
       btn} = '0;
      wheel = 1'b1;
      state = mre_pkg::DEV_DEFAULT;
      i_reset = 1'b1;
      tick(4);
      i_reset = 1'b0;
      t_unconf;
      t_report;
      t_button;
      t_nowheel;
      t_halt;
      t_query;
      t_idle;
      close_out;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         close_out;
      end
   end
endmodule
bind mre_endpoint mre_endpoint_sva chk_u (
   .i_clk                            (i_clk),
   .i_reset                          (i_reset),
   .i_dev_state                      (i_dev_state),
   .i_report_endpoint_poll           (i_report_endpoint_poll),
   .i_halt_report_endpoint_request   (i_halt_report_endpoint_request),
   .i_unhalt_report_endpoint_request (i_unhalt_report_endpoint_request),
   .i_query_valid                    (i_query_valid),
   .i_query_wlength                  (i_query_wlength),
   .i_wheel_present                  (i_wheel_present),
   .o_resp_valid                     (o_resp_valid),
   .o_resp_kind                      (o_resp_kind),
   .o_resp_len                       (o_resp_len),
   .o_ctrl_valid                     (o_ctrl_valid),
   .o_ctrl_stall                     (o_ctrl_stall),
   .o_halted                         (o_halted),
   .o_query_valid                    (o_query_valid),
   .o_query_len                      (o_query_len)
);
`default_nettype wire
